/* verilog/apmc_pkg.sv */
`default_nettype none
package apmc_pkg;
   localparam int unsigned clk_mhz = 40;
   localparam int unsigned conv_time_ns = 300;
   localparam int unsigned conv_cycles = (conv_time_ns * clk_mhz + 999) / 1000;
   localparam int unsigned nap_wake_ns = 200;
   localparam int unsigned nap_wake_cycles = (nap_wake_ns * clk_mhz + 999) / 1000;
   localparam int unsigned pwrup_wake_ns = 10000;
   localparam int unsigned pwrup_wake_cycles = (pwrup_wake_ns * clk_mhz + 999) / 1000;
   localparam logic [7:0] unlock_addr = 8'h11;
   localparam logic [7:0] unlock_key = 8'h69;
   localparam logic [7:0] sleep_ctrl_addr = 8'h10;
   localparam int unsigned nap_en_bit = 1;
   localparam int unsigned deep_req_bit = 0;
   localparam logic [7:0] sleep_ctrl_reset = 8'h00;
   localparam int unsigned cnt_w = 16;
   typedef enum logic [4:0] {
      apmc_acq_s = 5'h01,
      apmc_conv_s = 5'h02,
      apmc_nap_s = 5'h04,
      apmc_deep_s = 5'h08,
      apmc_wake_s = 5'h10
   } apmc_state_t;
endpackage
`default_nettype wire

/* verilog/apmc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface apmc_if;
   logic conversion_start_pin;
   logic cs_n;
   logic wr_stb;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic ready_indicator_pin;
   modport device (input conversion_start_pin, cs_n, wr_stb, wr_addr, wr_data,
      output ready_indicator_pin);
   modport host (output conversion_start_pin, cs_n, wr_stb, wr_addr, wr_data,
      input ready_indicator_pin);
endinterface
`default_nettype wire

/* verilog/apmc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module apmc_timer #(
   parameter int unsigned W = 16
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] cnt_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_ff <= '0;
      end else if (load) begin
         cnt_ff <= count;
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - 1'b1;
      end
   end
   // registered only, so a caller may load on done without a loop
   assign done = (cnt_ff == '0);
endmodule
`default_nettype wire

/* verilog/apmc_device.sv */
`timescale 1ns/1ps
`default_nettype none
module apmc_device #(
   parameter int unsigned conv_cyc = apmc_pkg::conv_cycles,
   parameter int unsigned pwrup_cyc = apmc_pkg::pwrup_wake_cycles
) (
   input wire logic clk,
   input wire logic resetn,
   apmc_if.device link,
   output logic analog_on,
   output logic partial_on,
   output logic conv_busy,
   output logic conv_done,
   output logic deep_sleep_mode,
   output logic [7:0] sleep_control_register
);
   import apmc_pkg::*;
   apmc_state_t state_ff, nxt_state;
   logic cst_d_ff, cs_d_ff, unlocked_ff, tmr_load, tmr_done;
   logic [7:0] ctl_ff;
   logic [cnt_w-1:0] tmr_count;
   logic cst_rise, cst_fall, cs_rise;
   assign cst_rise = link.conversion_start_pin && !cst_d_ff;
   assign cst_fall = !link.conversion_start_pin && cst_d_ff;
   assign cs_rise = link.cs_n && !cs_d_ff;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cst_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
      end else begin
         cst_d_ff <= link.conversion_start_pin;
         cs_d_ff <= link.cs_n;
      end
   end
   // key opens one write to the control register, which relocks it
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         unlocked_ff <= 1'b0;
      end else if (link.wr_stb && link.wr_addr == unlock_addr) begin
         unlocked_ff <= (link.wr_data == unlock_key);
      end else if (link.wr_stb && link.wr_addr == sleep_ctrl_addr) begin
         unlocked_ff <= 1'b0;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl_ff <= sleep_ctrl_reset;
      end else if (link.wr_stb && link.wr_addr == sleep_ctrl_addr) begin
         ctl_ff[nap_en_bit] <= link.wr_data[nap_en_bit];
         // clearing the request needs no key so exit is always possible
         if (unlocked_ff || !link.wr_data[deep_req_bit]) begin
            ctl_ff[deep_req_bit] <= link.wr_data[deep_req_bit];
         end
      end
   end
   always_comb begin
      nxt_state = state_ff;
      tmr_load = 1'b0;
      tmr_count = '0;
      case (state_ff)
         apmc_acq_s: begin
            if (ctl_ff[deep_req_bit] && cs_rise) begin
               nxt_state = apmc_deep_s;
            end else if (cst_rise) begin
               nxt_state = apmc_conv_s;
               tmr_load = 1'b1;
               tmr_count = cnt_w'(conv_cyc);
            end
         end
         apmc_conv_s: begin
            if (tmr_done) begin
               if (ctl_ff[nap_en_bit] && link.conversion_start_pin) begin
                  nxt_state = apmc_nap_s;
               end else begin
                  nxt_state = apmc_acq_s;
               end
            end
         end
         apmc_nap_s: begin
            if (ctl_ff[deep_req_bit] && cs_rise) begin
               nxt_state = apmc_deep_s;
            end else if (cst_fall) begin
               nxt_state = apmc_acq_s;
            end
         end
         apmc_deep_s: begin
            if (!ctl_ff[deep_req_bit]) begin
               nxt_state = apmc_wake_s;
               tmr_load = 1'b1;
               tmr_count = cnt_w'(pwrup_cyc);
            end
         end
         apmc_wake_s: begin
            // starts are ignored here and in deep sleep
            if (tmr_done) begin
               nxt_state = apmc_acq_s;
            end
         end
         default: nxt_state = apmc_acq_s;
      endcase
   end
   apmc_timer #(.W(cnt_w)) u_tmr (
      .clk(clk),
      .resetn(resetn),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_ff <= apmc_acq_s;
      end else begin
         state_ff <= nxt_state;
      end
   end
   // outputs except conv_done and sleep_control_register follow the next state so they switch together with the state
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         analog_on <= 1'b1;
      end else begin
         analog_on <= !(nxt_state == apmc_deep_s || nxt_state == apmc_wake_s);
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         partial_on <= 1'b1;
      end else begin
         partial_on <= (nxt_state != apmc_nap_s) && (nxt_state != apmc_deep_s)
            && (nxt_state != apmc_wake_s);
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_busy <= 1'b0;
      end else begin
         conv_busy <= (nxt_state == apmc_conv_s);
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         conv_done <= 1'b0;
      end else begin
         conv_done <= (state_ff == apmc_conv_s) && tmr_done;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         deep_sleep_mode <= 1'b0;
      end else begin
         deep_sleep_mode <= (nxt_state == apmc_deep_s);
      end
   end
   // ready stays high while waking, so the host must time the wake itself
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         link.ready_indicator_pin <= 1'b1;
      end else begin
         link.ready_indicator_pin <= (nxt_state != apmc_conv_s);
      end
   end
   assign sleep_control_register = ctl_ff;
endmodule
`default_nettype wire

/* verilog/apmc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module apmc_host #(
   parameter int unsigned conv_cyc = apmc_pkg::conv_cycles,
   parameter int unsigned nap_cyc = apmc_pkg::nap_wake_cycles,
   parameter int unsigned pwrup_cyc = apmc_pkg::pwrup_wake_cycles
) (
   input wire logic clk,
   input wire logic resetn,
   apmc_if.host link,
   input wire logic start_req,
   input wire logic nap_enable,
   input wire logic sleep_req,
   input wire logic wake_req,
   output logic start_ok,
   output logic busy
);
   import apmc_pkg::*;
   logic [2:0] step_ff;
   logic cst_ff, cs_ff, stb_ff, hold_ff, nap_sent_ff, tmr_load, tmr_done;
   logic [7:0] addr_ff, data_ff;
   logic [cnt_w-1:0] tmr_count;
   assign link.conversion_start_pin = cst_ff;
   assign link.cs_n = cs_ff;
   assign link.wr_stb = stb_ff;
   assign link.wr_addr = addr_ff;
   assign link.wr_data = data_ff;
   assign start_ok = (step_ff == 3'h0) && !cst_ff && tmr_done && !hold_ff;
   assign busy = !start_ok;
   always_comb begin
      tmr_load = 1'b0;
      tmr_count = '0;
      // wake guard starts on the very edge that drops the start pin
      if (step_ff == 3'h0 && cst_ff && tmr_done && !(nap_enable && start_req)) begin
         tmr_load = 1'b1;
         tmr_count = cnt_w'(nap_cyc);
      end else if (step_ff == 3'h5) begin
         tmr_load = 1'b1;
         // device starts its own count two cycles after the clearing write leaves here
         tmr_count = cnt_w'(pwrup_cyc + 2);
      end else if (start_ok && start_req) begin
         tmr_load = 1'b1;
         tmr_count = cnt_w'(conv_cyc);
      end
   end
   apmc_timer #(.W(cnt_w)) u_tmr (
      .clk(clk),
      .resetn(resetn),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );
   // 1: unlock, 2: set request, 3: raise cs, 4: light-sleep bit, 5: clear request
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         step_ff <= 3'h0;
         cst_ff <= 1'b0;
         cs_ff <= 1'b1;
         stb_ff <= 1'b0;
         hold_ff <= 1'b0;
         nap_sent_ff <= sleep_ctrl_reset[nap_en_bit];
         addr_ff <= 8'h00;
         data_ff <= 8'h00;
      end else begin
         stb_ff <= 1'b0;
         cs_ff <= 1'b1;
         case (step_ff)
            3'h0: begin
               if (start_ok && start_req) begin
                  cst_ff <= 1'b1;
               end else if (cst_ff && tmr_done && !(nap_enable && start_req)) begin
                  cst_ff <= 1'b0;
               end else if (!cst_ff && !hold_ff && nap_enable != nap_sent_ff) begin
                  step_ff <= 3'h4;
               end else if (sleep_req && !cst_ff && tmr_done && !hold_ff) begin
                  step_ff <= 3'h1;
               end else if (wake_req && hold_ff) begin
                  step_ff <= 3'h5;
               end
            end
            3'h4: begin
               stb_ff <= 1'b1;
               cs_ff <= 1'b0;
               addr_ff <= sleep_ctrl_addr;
               data_ff <= 8'h00;
               data_ff[nap_en_bit] <= nap_enable;
               nap_sent_ff <= nap_enable;
               step_ff <= 3'h0;
            end
            3'h1: begin
               stb_ff <= 1'b1;
               cs_ff <= 1'b0;
               addr_ff <= unlock_addr;
               data_ff <= unlock_key;
               step_ff <= 3'h2;
            end
            3'h2: begin
               stb_ff <= 1'b1;
               cs_ff <= 1'b0;
               addr_ff <= sleep_ctrl_addr;
               data_ff <= 8'h00;
               data_ff[deep_req_bit] <= 1'b1;
               data_ff[nap_en_bit] <= nap_enable;
               nap_sent_ff <= nap_enable;
               step_ff <= 3'h3;
            end
            3'h3: begin
               hold_ff <= 1'b1;
               step_ff <= 3'h0;
            end
            3'h5: begin
               stb_ff <= 1'b1;
               cs_ff <= 1'b0;
               addr_ff <= sleep_ctrl_addr;
               data_ff <= 8'h00;
               data_ff[nap_en_bit] <= nap_enable;
               nap_sent_ff <= nap_enable;
               hold_ff <= 1'b0;
               step_ff <= 3'h0;
            end
            default: step_ff <= 3'h0;
         endcase
      end
   end
endmodule
`default_nettype wire

/* dv/apmc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module apmc_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic conversion_start_pin,
   input wire logic cs_n,
   input wire logic wr_stb,
   input wire logic ready_indicator_pin,
   input wire logic analog_on,
   input wire logic partial_on,
   input wire logic conv_busy,
   input wire logic conv_done,
   input wire logic deep_sleep_mode,
   input wire logic [7:0] sleep_control_register
);
   import apmc_pkg::*;
   logic [15:0] len_ff;
   logic [15:0] first_ff;
   logic seen_ff;
   logic fall;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   assign fall = !conv_busy && (len_ff != 16'h0000);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         len_ff <= 16'h0000;
      end else begin
         len_ff <= conv_busy ? len_ff + 16'h0001 : 16'h0000;
      end
   end
   // first conversion sets the reference length for all later ones
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         first_ff <= 16'h0000;
         seen_ff <= 1'b0;
      end else if (fall && !seen_ff) begin
         first_ff <= len_ff;
         seen_ff <= 1'b1;
      end
   end
   a_conv_len_fixed: assert property (fall && seen_ff |-> len_ff == first_ff)
      else $error("conversion length changed");
   a_start_begins_conv: assert property (
      $rose(conversion_start_pin) && analog_on && partial_on && !conv_busy
      |-> ##[1:2] conv_busy)
      else $error("start edge did not begin a conversion");
   a_nap_entry: assert property (
      conv_done && conversion_start_pin && sleep_control_register[nap_en_bit]
      |-> ##[1:2] !partial_on)
      else $error("light sleep not entered");
   a_nap_hold: assert property (
      !partial_on && analog_on && conversion_start_pin |=> !partial_on)
      else $error("light sleep left while start high");
   a_deep_entry: assert property (
      $rose(cs_n) && sleep_control_register[deep_req_bit] |-> ##[1:3] deep_sleep_mode)
      else $error("deep sleep not entered after select rise");
   a_deep_analog_off: assert property (deep_sleep_mode |-> !analog_on && !partial_on)
      else $error("analog powered in deep sleep");
   a_deep_keeps_regs: assert property (
      deep_sleep_mode && !wr_stb |=> $stable(sleep_control_register))
      else $error("register changed in deep sleep");
   a_ready_in_deep: assert property (deep_sleep_mode |-> ready_indicator_pin)
      else $error("ready low in deep sleep");
   a_wake_ready_high: assert property (
      $fell(deep_sleep_mode) |-> ready_indicator_pin && !analog_on)
      else $error("wake start without ready high");
   a_ignore_asleep: assert property (
      $rose(conversion_start_pin) && !analog_on |-> ##1 !conv_busy [*2])
      else $error("conversion began while unpowered");
endmodule
`default_nettype wire

/* dv/apmc_test.sv */
`timescale 1ns/1ps
`default_nettype none
module apmc_test;
   localparam int unsigned conv_cyc = 4;
   localparam int unsigned pwrup_cyc = 8;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic start_req = 1'b0;
   logic nap_enable = 1'b0;
   logic sleep_req = 1'b0;
   logic wake_req = 1'b0;
   logic start_ok, busy, analog_on, partial_on, conv_busy, conv_done, deep_sleep_mode;
   logic [7:0] sleep_control_register;
   int num_errors = 0;
   int comparisons = 0;
   apmc_if link ();
   always #12.5 clk = ~clk;
   apmc_device #(.conv_cyc(conv_cyc), .pwrup_cyc(pwrup_cyc)) i_apmc_device (.clk(clk),
      .resetn(resetn), .link(link), .analog_on(analog_on), .partial_on(partial_on),
      .conv_busy(conv_busy), .conv_done(conv_done), .deep_sleep_mode(deep_sleep_mode),
      .sleep_control_register(sleep_control_register));
   apmc_host #(.conv_cyc(conv_cyc), .pwrup_cyc(pwrup_cyc)) i_apmc_host (.clk(clk),
      .resetn(resetn), .link(link), .start_req(start_req), .nap_enable(nap_enable),
      .sleep_req(sleep_req), .wake_req(wake_req), .start_ok(start_ok), .busy(busy));
   apmc_monitor i_apmc_monitor (.clk(clk), .resetn(resetn),
      .conversion_start_pin(link.conversion_start_pin), .cs_n(link.cs_n),
      .wr_stb(link.wr_stb), .ready_indicator_pin(link.ready_indicator_pin),
      .analog_on(analog_on), .partial_on(partial_on), .conv_busy(conv_busy),
      .conv_done(conv_done), .deep_sleep_mode(deep_sleep_mode),
      .sleep_control_register(sleep_control_register));
   task print_verdict();
      $display("comparisons %0d num_errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task check(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         num_errors++;
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // bounded wait, so a dead design ends in a mismatch rather than a hang
   task conv_cycle();
      int i;
      @(posedge clk) start_req <= 1'b1;
      for (i = 0; i < 60 && conv_done !== 1'b1; i++) tick(1);
      check(conv_done, 1'b1);
   endtask
   task wait_deep(input logic v);
      int i;
      for (i = 0; i < 60 && deep_sleep_mode !== v; i++) tick(1);
      check(deep_sleep_mode, v);
   endtask
   task t_normal();
      repeat (2) begin
         conv_cycle();
         check(analog_on, 1'b1);
         check(partial_on, 1'b1);
         @(posedge clk) start_req <= 1'b0;
         tick(4);
      end
   endtask
   task t_nap();
      @(posedge clk) nap_enable <= 1'b1;
      tick(10);
      conv_cycle();
      tick(3);
      check(partial_on, 1'b0);
      tick(10);
      check(partial_on, 1'b0);
      @(posedge clk) start_req <= 1'b0;
      tick(4);
      check(partial_on, 1'b1);
      tick(12);
      conv_cycle();
      @(posedge clk) start_req <= 1'b0;
      nap_enable <= 1'b0;
      tick(10);
   endtask
   task t_deep();
      @(posedge clk) sleep_req <= 1'b1;
      wait_deep(1'b1);
      check(link.ready_indicator_pin, 1'b1);
      check(analog_on, 1'b0);
      @(posedge clk) sleep_req <= 1'b0;
      start_req <= 1'b1;
      tick(10);
      check(conv_busy, 1'b0);
      check(start_ok, 1'b0);
      check(deep_sleep_mode, 1'b1);
      @(posedge clk) start_req <= 1'b0;
      tick(2);
   endtask
   task t_wake();
      @(posedge clk) wake_req <= 1'b1;
      wait_deep(1'b0);
      check(link.ready_indicator_pin, 1'b1);
      check(analog_on, 1'b0);
      check(busy, 1'b1);
      check(sleep_control_register[apmc_pkg::deep_req_bit], 1'b0);
      @(posedge clk) wake_req <= 1'b0;
      tick(pwrup_cyc + 4);
      check(analog_on, 1'b1);
      conv_cycle();
      @(posedge clk) start_req <= 1'b0;
      tick(4);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      @(posedge clk) resetn <= 1'b1;
      tick(2);
      t_normal();
      t_nap();
      t_deep();
      t_wake();
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
